// ---- include/sfc_pkg.sv ----
`default_nettype none
package sfc_pkg;
   // Core clock and link rates
   localparam longint unsigned CLK_HZ        = 50_000_000;
   localparam longint unsigned RATE_FAST_BPS = 12_000_000;
   localparam longint unsigned RATE_SLOW_BPS = 400_000;
   // Half periods round up so the link never runs above its rate
   localparam int HALF_FAST = int'((CLK_HZ + 2 * RATE_FAST_BPS - 1) / (2 * RATE_FAST_BPS));
   localparam int HALF_SLOW = int'((CLK_HZ + 2 * RATE_SLOW_BPS - 1) / (2 * RATE_SLOW_BPS));
   // Busy-wait limits, longest times round down
   localparam longint unsigned TO_WRSR_MS   = 30;
   localparam longint unsigned TO_PAGE_MS   = 10;
   localparam longint unsigned TO_ERASE_S   = 320;
   localparam longint unsigned TO_WRSR_CYC  = TO_WRSR_MS * CLK_HZ / 1000;
   localparam longint unsigned TO_PAGE_CYC  = TO_PAGE_MS * CLK_HZ / 1000;
   localparam longint unsigned TO_ERASE_CYC = TO_ERASE_S * CLK_HZ;
   // Flash opcodes and status layout
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_RDSR = 8'h05;
   localparam logic [7:0] DUMMY    = 8'hFF;
   localparam int         WIP_BIT  = 0;
   localparam int         HDR_BYTES = 4;
   // Picture index: 2-byte width, 2-byte height, 4-byte start address
   localparam int         IDX_BITS        = 13;
   localparam int         IDX_ENTRY_BYTES = 8;
   localparam int         IDX_SHIFT       = 3;
   localparam logic [23:0] IDX_BASE_DEF   = 24'h000000;
   // Read stream buffer
   localparam int FIFO_DEPTH = 4;
   // Command codes
   localparam logic [2:0] OP_XFER  = 3'h0;
   localparam logic [2:0] OP_READ  = 3'h1;
   localparam logic [2:0] OP_INDEX = 3'h2;
   localparam logic [2:0] OP_POLL  = 3'h3;
   // Poll kinds
   localparam logic [1:0] PK_WRSR  = 2'h0;
   localparam logic [1:0] PK_PAGE  = 2'h1;
   localparam logic [1:0] PK_ERASE = 2'h2;
endpackage
`default_nettype wire

// ---- hdl/sfc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = sfc_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_reset,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0]               cnt;
      logic                        in_rdy;
      logic                        out_vld;
   } sfc_fifo_regs_t;

   localparam sfc_fifo_regs_t RST = '{in_rdy: 1'b1, default: '0};

   sfc_fifo_regs_t              r;
   sfc_fifo_regs_t              n;
   logic                        push;
   logic                        pop;
   logic [DEPTH-1:0][WIDTH-1:0] sh;
   logic [CW-1:0]               wr_idx;

   // Head always sits in entry 0, so the output is a flop
   assign push = i_in_valid & r.in_rdy;
   assign pop  = r.out_vld & i_out_ready;

   // Entries move down one place on a pop
   for (genvar i = 0; i < DEPTH; i++) begin : g_shift
      if (i == DEPTH - 1) begin : g_top
         assign sh[i] = pop ? '0 : r.mem[i];
      end else begin : g_mid
         assign sh[i] = pop ? r.mem[i+1] : r.mem[i];
      end
   end

   // Next state
   always_comb begin
      n = r;
      n.mem = sh;
      wr_idx = CW'(r.cnt - CW'(pop));
      if (push) begin
         n.mem[wr_idx] = i_in_data;
      end
      n.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
      n.in_rdy = (n.cnt != CW'(DEPTH));
      n.out_vld = (n.cnt != '0);
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   assign o_in_ready  = r.in_rdy;
   assign o_out_valid = r.out_vld;
   assign o_out_data  = r.mem[0];
endmodule
`default_nettype wire

// ---- hdl/sfc_spi_master.sv ----
// Notes on behaviour
// - One serial channel; this block is always master, drives clock and MOSI, samples MISO.
// - Two active-low selects, card and flash; only the chosen one is asserted.
// - Clock runs at most 12 Mbps, and at 400 kbps only during card initialisation.
// - Font and picture data are fetched from the flash over the link and streamed out.
// - Small glyphs use the internal font store; large ones are read from flash.
// - An index entry is a two-byte width, a two-byte height and a four-byte start address.
// - The picture index holds at most 8192 entries.
// - With the timeout off, the default, status polling continues until the flash is idle.
// - Timeout on: polling stops after 30 ms (status write), 10 ms (page) or 320 s (erase).
`timescale 1ns/1ps
`default_nettype none
module sfc_spi_master #(
   parameter int unsigned DEPTH     = sfc_pkg::FIFO_DEPTH,
   parameter logic [35:0] WRSR_CYC  = 36'(sfc_pkg::TO_WRSR_CYC),
   parameter logic [35:0] PAGE_CYC  = 36'(sfc_pkg::TO_PAGE_CYC),
   parameter logic [35:0] ERASE_CYC = 36'(sfc_pkg::TO_ERASE_CYC),
   parameter logic [23:0] IDX_BASE  = sfc_pkg::IDX_BASE_DEF
) (
   // Clock and reset
   input  wire logic                         i_core_clk,
   input  wire logic                         i_reset,
   // Command port
   input  wire logic                         i_cmd_valid,
   output logic                              o_cmd_ready,
   input  wire logic [2:0]                   i_cmd_op,
   input  wire logic                         i_cmd_card,
   input  wire logic                         i_cmd_hold,
   input  wire logic                         i_cmd_small,
   input  wire logic [7:0]                   i_cmd_data,
   input  wire logic [23:0]                  i_cmd_addr,
   input  wire logic [15:0]                  i_cmd_len,
   input  wire logic [sfc_pkg::IDX_BITS-1:0] i_cmd_index,
   input  wire logic [1:0]                   i_cmd_poll,
   input  wire logic                         i_slow_init,
   input  wire logic                         i_timeout_en,
   // Results
   output logic                              o_done,
   output logic                              o_timed_out,
   output logic                              o_internal,
   output logic [7:0]                        o_xfer_rx,
   output logic [15:0]                       o_img_width,
   output logic [15:0]                       o_img_height,
   output logic [31:0]                       o_img_addr,
   // Read stream
   output logic                              o_rd_valid,
   output logic [7:0]                        o_rd_data,
   input  wire logic                         i_rd_ready,
   // Link pins
   output logic                              o_serial_clock_out,
   output logic                              o_mosi,
   input  wire logic                         i_miso,
   output logic                              o_card_select_n,
   output logic                              o_flash_select_n
);
   localparam int         HALF_F = sfc_pkg::HALF_FAST;
   localparam int         HALF_S = sfc_pkg::HALF_SLOW;
   localparam logic [6:0] RLD_F  = 7'(sfc_pkg::HALF_FAST - 1);
   localparam logic [6:0] RLD_S  = 7'(sfc_pkg::HALF_SLOW - 1);
   localparam logic [15:0] HDR   = 16'(sfc_pkg::HDR_BYTES);

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_NEXT = 6'h02,
      S_LOW  = 6'h04,
      S_HIGH = 6'h08,
      S_GAP  = 6'h10,
      S_DONE = 6'h20
   } sfc_state_t;

   typedef struct packed {
      sfc_state_t  st;
      logic [2:0]  op;
      logic        hold;
      logic        slow;
      logic        to_en;
      logic [23:0] addr;
      logic [15:0] len;
      logic [15:0] nb;
      logic [7:0]  tx;
      logic [7:0]  rx;
      logic [2:0]  bitn;
      logic [6:0]  div;
      logic [6:0]  hi;
      logic [35:0] tcnt;
      logic [35:0] tlim;
      logic [63:0] idx;
      logic [2:0]  miso_s;
      logic        miso_f;
      logic        sck;
      logic        mosi;
      logic        card_n;
      logic        flash_n;
      logic        ready;
      logic        done;
      logic        timed_out;
      logic        internal;
      logic [7:0]  xrx;
   } sfc_regs_t;

   localparam sfc_regs_t RST = '{st: S_IDLE, mosi: 1'b1, card_n: 1'b1, flash_n: 1'b1,
                                 miso_f: 1'b1, miso_s: 3'h7, default: '0};

   sfc_regs_t  r;
   sfc_regs_t  n;
   logic       tick;
   logic       push;
   logic [7:0] rxb;
   logic       slow_new;
   logic       fifo_rdy;
   logic       last;

   // Header bytes, then filler clocked out while reading
   function automatic logic [7:0] tx_byte(input logic [2:0] op, input logic [15:0] nb,
                                          input logic [23:0] a);
      tx_byte = sfc_pkg::DUMMY;
      if (op == sfc_pkg::OP_POLL) begin
         if (nb == 16'h0000) tx_byte = sfc_pkg::CMD_RDSR;
      end else if (nb == 16'h0000) begin
         tx_byte = sfc_pkg::CMD_READ;
      end else if (nb == 16'h0001) begin
         tx_byte = a[23:16];
      end else if (nb == 16'h0002) begin
         tx_byte = a[15:8];
      end else if (nb == 16'h0003) begin
         tx_byte = a[7:0];
      end
   endfunction

   // Next state
   always_comb begin
      n = r;
      n.done = 1'b0;
      push = 1'b0;
      rxb = {r.rx[6:0], r.miso_f};
      last = (17'(r.nb) + 17'h00001) == (17'(HDR) + 17'(r.len));
      slow_new = i_slow_init & i_cmd_card & (i_cmd_op == sfc_pkg::OP_XFER);
      // MISO filter: a change counts once stages two and three agree
      n.miso_s = {r.miso_s[1:0], i_miso};
      if (r.miso_s[1] == r.miso_s[2]) n.miso_f = r.miso_s[2];
      // Half-bit enable divider
      tick = (r.div == 7'h00);
      n.div = tick ? (r.slow ? RLD_S : RLD_F) : 7'(r.div - 7'h01);
      n.hi = r.sck ? 7'(r.hi + 7'h01) : 7'h00;
      if (r.op == sfc_pkg::OP_POLL && r.st != S_IDLE) n.tcnt = 36'(r.tcnt + 36'h1);
      case (r.st)
         S_IDLE: begin
            if (i_cmd_valid && r.ready) begin
               n.ready = 1'b0;
               n.op = i_cmd_op;
               n.hold = i_cmd_hold;
               n.to_en = i_timeout_en;
               n.tcnt = 36'h0;
               n.tlim = (i_cmd_poll == sfc_pkg::PK_WRSR) ? WRSR_CYC :
                        (i_cmd_poll == sfc_pkg::PK_PAGE) ? PAGE_CYC : ERASE_CYC;
               n.timed_out = 1'b0;
               n.internal = 1'b0;
               n.nb = 16'h0000;
               n.slow = slow_new;
               if (i_cmd_op == sfc_pkg::OP_XFER) begin
                  // Switching target swaps selects in one edge, never both low
                  n.card_n = ~i_cmd_card;
                  n.flash_n = i_cmd_card;
                  n.tx = i_cmd_data;
                  n.mosi = i_cmd_data[7];
                  n.bitn = 3'h0;
                  n.div = slow_new ? RLD_S : RLD_F;
                  n.st = S_LOW;
               end else if (i_cmd_op == sfc_pkg::OP_READ && i_cmd_small) begin
                  n.internal = 1'b1;
                  n.st = S_DONE;
               end else if (i_cmd_op == sfc_pkg::OP_READ || i_cmd_op == sfc_pkg::OP_INDEX ||
                            i_cmd_op == sfc_pkg::OP_POLL) begin
                  n.card_n = 1'b1;
                  n.flash_n = 1'b0;
                  n.addr = i_cmd_addr;
                  n.len = i_cmd_len;
                  if (i_cmd_op == sfc_pkg::OP_INDEX) begin
                     // Index field is 13 bits wide, so 8192 entries at most
                     n.addr = 24'(IDX_BASE + 24'({i_cmd_index, 3'h0}));
                     n.len = 16'(sfc_pkg::IDX_ENTRY_BYTES);
                  end
                  n.st = S_NEXT;
               end else begin
                  n.st = S_DONE;
               end
            end else begin
               // Ready rises on the first edge out of reset
               n.ready = 1'b1;
            end
         end
         S_NEXT: begin
            // Stall before a data byte while the stream buffer is full
            if (!(r.op == sfc_pkg::OP_READ && r.nb >= HDR && !fifo_rdy)) begin
               n.tx = tx_byte(r.op, r.nb, r.addr);
               n.mosi = n.tx[7];
               n.bitn = 3'h0;
               n.div = r.slow ? RLD_S : RLD_F;
               n.st = S_LOW;
            end
         end
         S_LOW: begin
            if (tick) begin
               n.sck = 1'b1;
               n.st = S_HIGH;
            end
         end
         S_HIGH: begin
            if (tick) begin
               // MISO is caught at the falling edge: the filter delay is
               // four core clocks, about one fast half bit, so this is the rising-edge value
               n.sck = 1'b0;
               n.rx = rxb;
               if (r.bitn != 3'h7) begin
                  n.bitn = 3'(r.bitn + 3'h1);
                  n.tx = {r.tx[6:0], 1'b0};
                  n.mosi = r.tx[6];
                  n.st = S_LOW;
               end else if (r.op == sfc_pkg::OP_XFER) begin
                  n.xrx = rxb;
                  if (!r.hold) begin
                     n.card_n = 1'b1;
                     n.flash_n = 1'b1;
                  end
                  n.st = S_DONE;
               end else if (r.op == sfc_pkg::OP_POLL) begin
                  if (r.nb == 16'h0000) begin
                     n.nb = 16'h0001;
                     n.st = S_NEXT;
                  end else begin
                     n.flash_n = 1'b1;
                     if (!rxb[sfc_pkg::WIP_BIT]) begin
                        n.st = S_DONE;
                     end else if (r.to_en && r.tcnt >= r.tlim) begin
                        n.timed_out = 1'b1;
                        n.st = S_DONE;
                     end else begin
                        n.st = S_GAP;
                     end
                  end
               end else begin
                  if (r.nb >= HDR) begin
                     if (r.op == sfc_pkg::OP_READ) begin
                        push = 1'b1;
                     end else begin
                        // Width, height, start address, most significant first
                        n.idx = {r.idx[55:0], rxb};
                     end
                  end
                  if (last) begin
                     n.flash_n = 1'b1;
                     n.st = S_DONE;
                  end else begin
                     n.nb = 16'(r.nb + 16'h0001);
                     n.st = S_NEXT;
                  end
               end
            end
         end
         S_GAP: begin
            // Select stays high one half bit between status reads
            if (tick) begin
               n.flash_n = 1'b0;
               n.nb = 16'h0000;
               n.st = S_NEXT;
            end
         end
         S_DONE: begin
            n.done = 1'b1;
            n.ready = 1'b1;
            n.st = S_IDLE;
         end
         default: begin
            n.st = S_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   // Stream buffer between the link and the drawing engine
   sfc_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_reset     (i_reset),
      .i_in_valid  (push),
      .i_in_data   (rxb),
      .o_in_ready  (fifo_rdy),
      .o_out_valid (o_rd_valid),
      .o_out_data  (o_rd_data),
      .i_out_ready (i_rd_ready)
   );

   // Outputs straight from the state flops
   assign o_cmd_ready        = r.ready;
   assign o_done             = r.done;
   assign o_timed_out        = r.timed_out;
   assign o_internal         = r.internal;
   assign o_xfer_rx          = r.xrx;
   assign o_img_width        = r.idx[63:48];
   assign o_img_height       = r.idx[47:32];
   assign o_img_addr         = r.idx[31:0];
   assign o_serial_clock_out = r.sck;
   assign o_mosi             = r.mosi;
   assign o_card_select_n    = r.card_n;
   assign o_flash_select_n   = r.flash_n;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   chk_one_select: assert property (o_card_select_n || o_flash_select_n)
      else $error("both selects low");
   chk_idle_deselect: assert property ((r.st == S_IDLE && !r.hold) |->
      (o_card_select_n && o_flash_select_n))
      else $error("select low while idle");
   chk_clock_idle_low: assert property ((o_card_select_n && o_flash_select_n) |->
      !o_serial_clock_out)
      else $error("clock high with no select");
   chk_mosi_setup: assert property ($rose(o_serial_clock_out) |-> $stable(o_mosi))
      else $error("MOSI moved on rising edge");
   chk_fast_rate: assert property (($fell(o_serial_clock_out) && !r.slow) |->
      (r.hi == 7'(HALF_F)))
      else $error("fast high phase wrong");
   chk_slow_rate: assert property (($fell(o_serial_clock_out) && r.slow) |->
      (r.hi == 7'(HALF_S) && !$past(o_card_select_n)))
      else $error("slow high phase wrong");
   chk_small_glyph: assert property ((i_cmd_valid && o_cmd_ready &&
      i_cmd_op == sfc_pkg::OP_READ && i_cmd_small) |->
      ##2 (o_done && o_internal && o_flash_select_n))
      else $error("small glyph touched flash");
   chk_read_stall: assert property ((r.st == S_NEXT && r.op == sfc_pkg::OP_READ &&
      r.nb >= HDR && !fifo_rdy) |=> (r.st == S_NEXT && !o_serial_clock_out))
      else $error("read ran past full buffer");
   chk_timeout_off: assert property ($rose(o_timed_out) |->
      ($past(r.to_en) && $past(r.tcnt) >= $past(r.tlim)))
      else $error("timeout without enable or limit");
   chk_index_shift: assert property ((r.st == S_HIGH && tick && r.bitn == 3'h7 &&
      r.op == sfc_pkg::OP_INDEX && r.nb >= HDR) |=> (o_img_addr[7:0] == $past(rxb)))
      else $error("index byte not shifted in");

   cov_poll_timeout: cover property (o_done && o_timed_out);
   cov_read_stall: cover property (r.st == S_NEXT && r.op == sfc_pkg::OP_READ && !fifo_rdy);
   cov_slow_byte: cover property (o_done && r.slow);
endmodule
`default_nettype wire

// ---- test/sfc_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// Flash and card slaves sharing one link, mode 0
module sfc_partner (
   // Link pins
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_card_select_n,
   input  wire logic       i_flash_select_n,
   output logic            o_miso,
   // Test controls
   input  wire logic       i_busy,
   output logic [7:0]      o_last_rx
);
   logic [7:0]  sh_in;
   logic [7:0]  sh_out;
   logic [7:0]  op;
   logic [23:0] addr;
   int          bitn;
   int          byten;
   wire logic   sel = !i_card_select_n || !i_flash_select_n;

   // Reply for byte k of the current frame
   function automatic logic [7:0] reply(input int k);
      logic [23:0] a;
      a = addr + 24'(k - 4);
      if (!i_card_select_n) return 8'h3C;
      if (k == 0) return 8'hC3;
      if (op == 8'h05) return {7'h00, i_busy};
      if (op == 8'h03 && k >= 4) return a[7:0] ^ a[15:8] ^ 8'h5A;
      return 8'hFF;
   endfunction

   // First bit must be out before the first rising edge
   always @(negedge i_card_select_n or negedge i_flash_select_n) begin
      bitn = 0;
      byten = 0;
      sh_out = reply(0);
   end
   // Sample on rising edge, MSB first
   always @(posedge i_sck) begin
      if (sel) begin
         sh_in = {sh_in[6:0], i_mosi};
         bitn++;
         if (bitn == 8) begin
            o_last_rx = sh_in;
            if (byten == 0) op = sh_in;
            if (byten >= 1 && byten <= 3) addr = {addr[15:0], sh_in};
            byten++;
            bitn = 0;
         end
      end
   end
   // Drive on falling edge only
   always @(negedge i_sck) begin
      if (sel) sh_out = (bitn == 0) ? reply(byten) : {sh_out[6:0], 1'b1};
   end
   // Released line floats to its pull-up
   assign o_miso = sel ? sh_out[7] : 1'b1;
endmodule
`default_nettype wire

// ---- test/spi_flash_card_master_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_flash_card_master_test;
   logic clk = 0, rst = 1, cmd_valid = 0, cmd_card = 0, cmd_hold = 0, cmd_small = 0;
   logic slow = 0, to_en = 0, rd_ready = 0, busy = 0;
   logic [2:0]  cmd_op = 0;
   logic [7:0]  cmd_data = 0;
   logic [23:0] cmd_addr = 0;
   logic [15:0] cmd_len = 0;
   logic [12:0] cmd_index = 0;
   logic [1:0]  cmd_poll = 0;
   logic        cmd_ready, done, timed_out, internal, rd_valid;
   logic        sck, mosi, miso, csn_card, csn_flash;
   logic [7:0]  xfer_rx, rd_data, last_rx;
   logic [15:0] w, h;
   logic [31:0] iaddr;
   int failures = 0, n_tests = 0, done_cnt = 0, base = 0, cyc = 0;
   int hi_run = 0, last_hi = 0, flash_falls = 0;

   // Short poll limits keep the run brief
   sfc_spi_master #(.WRSR_CYC(36'd200), .PAGE_CYC(36'd100), .ERASE_CYC(36'd300)) dut (
      .i_core_clk(clk), .i_reset(rst), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
      .i_cmd_op(cmd_op), .i_cmd_card(cmd_card), .i_cmd_hold(cmd_hold),
      .i_cmd_small(cmd_small), .i_cmd_data(cmd_data), .i_cmd_addr(cmd_addr),
      .i_cmd_len(cmd_len), .i_cmd_index(cmd_index), .i_cmd_poll(cmd_poll),
      .i_slow_init(slow), .i_timeout_en(to_en), .o_done(done), .o_timed_out(timed_out),
      .o_internal(internal), .o_xfer_rx(xfer_rx), .o_img_width(w), .o_img_height(h),
      .o_img_addr(iaddr), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .i_rd_ready(rd_ready), .o_serial_clock_out(sck), .o_mosi(mosi), .i_miso(miso),
      .o_card_select_n(csn_card), .o_flash_select_n(csn_flash));
   sfc_partner slave (.i_sck(sck), .i_mosi(mosi), .i_card_select_n(csn_card),
      .i_flash_select_n(csn_flash), .o_miso(miso), .i_busy(busy), .o_last_rx(last_rx));

   initial forever #10 clk = ~clk;

   task check(input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   // Link watch; also measures the clock high phase
   always @(negedge clk) begin
      if (!rst) check(!csn_card && !csn_flash, 1'b0);
      if (!rst && csn_card && csn_flash) check(sck, 1'b0);
      if (sck) hi_run++;
      else begin
         if (hi_run > 0) last_hi = hi_run;
         hi_run = 0;
      end
   end
   always @(posedge clk) if (done === 1'b1) done_cnt++;
   always @(negedge csn_flash) flash_falls++;

   // Valid raised once ready is seen or 5000 cycles pass, dropped one cycle later
   task issue(input logic [2:0] op);
      int n;
      n = 0;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      cmd_op = op;
      cmd_valid = 1;
      base = done_cnt;
      @(negedge clk);
      cmd_valid = 0;
   endtask

   task wait_done;
      cyc = 1;
      while (done_cnt == base && cyc < 40000) begin
         @(negedge clk);
         cyc++;
      end
      check(done_cnt - base, 1);
   endtask

   task t_reset;
      check({csn_card, csn_flash, sck, mosi, cmd_ready, done}, 6'b110100);
      rst = 0;
      @(negedge clk);
      check(cmd_ready, 1'b1);
   endtask

   task t_xfer(input logic card, input logic sl, input logic [7:0] rx, input int half);
      int ff;
      ff = flash_falls;
      cmd_card = card;
      slow = sl;
      cmd_data = 8'h96;
      issue(sfc_pkg::OP_XFER);
      wait_done;
      check(xfer_rx, rx);
      check(last_rx, 8'h96);
      check(last_hi, half);
      check(flash_falls - ff, card ? 0 : 1);
      slow = 0;
   endtask

   // Held select spans two bytes: one falling edge, second reply is filler
   task t_hold;
      int ff;
      ff = flash_falls;
      cmd_card = 0;
      cmd_hold = 1;
      cmd_data = 8'h96;
      issue(sfc_pkg::OP_XFER);
      wait_done;
      check({csn_card, csn_flash, xfer_rx}, {2'b10, 8'hC3});
      cmd_hold = 0;
      issue(sfc_pkg::OP_XFER);
      wait_done;
      check({csn_card, csn_flash, xfer_rx}, {2'b11, 8'hFF});
      check(flash_falls - ff, 1);
   endtask

   // Fifo fills, link stalls, then drains in flash order
   task t_read;
      logic [23:0] a;
      int n;
      cmd_addr = 24'h0012FD;
      cmd_len = 16'd6;
      issue(sfc_pkg::OP_READ);
      repeat (600) @(negedge clk);
      check({rd_valid, csn_flash, sck, done_cnt == base}, 4'b1001);
      rd_ready = 1;
      for (int i = 0; i < 6; i++) begin
         a = cmd_addr + 24'(i);
         n = 0;
         while (rd_valid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
         end
         check(rd_data, mem(a));
         @(negedge clk);
      end
      wait_done;
      check({rd_valid, internal}, 2'b00);
      rd_ready = 0;
   endtask

   task t_small;
      int ff;
      ff = flash_falls;
      cmd_small = 1;
      issue(sfc_pkg::OP_READ);
      wait_done;
      check({internal, 32'(flash_falls - ff)}, {1'b1, 32'h0});
      // Unused op code only finishes, no link activity
      issue(3'h5);
      wait_done;
      check({internal, csn_flash, csn_card, 32'(flash_falls - ff)}, {3'b011, 32'h0});
      cmd_small = 0;
   endtask

   task t_index(input logic [12:0] idx);
      logic [23:0] a;
      a = {8'h00, idx, 3'b000};
      cmd_index = idx;
      issue(sfc_pkg::OP_INDEX);
      wait_done;
      check(w, {mem(a), mem(a + 24'd1)});
      check(h, {mem(a + 24'd2), mem(a + 24'd3)});
      check(iaddr, {mem(a + 24'd4), mem(a + 24'd5), mem(a + 24'd6), mem(a + 24'd7)});
   endtask

   task t_poll(input logic [1:0] kind, input logic en, input int lim);
      cmd_poll = kind;
      to_en = en;
      busy = 1;
      issue(sfc_pkg::OP_POLL);
      if (!en) begin
         repeat (3) @(posedge csn_flash);
         @(negedge clk);
         busy = 0;
      end
      wait_done;
      check(timed_out, en);
      if (en) check(cyc + 5 >= lim && cyc <= lim + 250, 1'b1);
      busy = 0;
      to_en = 0;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_of_test;
   end

   initial begin
      repeat (16) @(negedge clk);
      t_reset;
      t_xfer(1'b0, 1'b0, 8'hC3, sfc_pkg::HALF_FAST);
      t_xfer(1'b1, 1'b1, 8'h3C, sfc_pkg::HALF_SLOW);
      t_xfer(1'b1, 1'b0, 8'h3C, sfc_pkg::HALF_FAST);
      t_xfer(1'b0, 1'b1, 8'hC3, sfc_pkg::HALF_FAST);
      t_hold;
      t_small;
      t_read;
      t_index(13'h0001);
      t_index(13'h1FFF);
      t_poll(sfc_pkg::PK_WRSR, 1'b0, 0);
      t_poll(sfc_pkg::PK_WRSR, 1'b1, 200);
      t_poll(sfc_pkg::PK_PAGE, 1'b1, 100);
      t_poll(sfc_pkg::PK_ERASE, 1'b1, 300);
      t_poll(2'h3, 1'b1, 300);
      end_of_test;
   end
endmodule
`default_nettype wire
